// File: rtl/data_bank_and_alu_status.v
`timescale 1ns/1ps
`default_nettype none
`include "data_bank_regs.vh"
module data_bank_and_alu_status
(
    // clock and reset
    input  wire        i_clk,
    input  wire        i_nrst,
    // instruction fields from decode
    input  wire        i_exec,
    input  wire [7:0]  i_file_addr,
    input  wire        i_access_sel,
    input  wire        i_ff_move,
    input  wire [11:0] i_ff_src,
    input  wire [11:0] i_ff_dst,
    input  wire        i_bank_load,
    input  wire [7:0]  i_literal,
    input  wire [3:0]  i_op,
    input  wire [7:0]  i_alu_b,
    input  wire        i_write_file,
    // special register addresses that land on this block
    input  wire [11:0] i_status_addr,
    input  wire [11:0] i_bank_addr,
    // data ram side
    input  wire [7:0]  i_ram_rdata,
    output wire [11:0] o_rd_addr,
    output wire [11:0] o_wr_addr,
    output wire        o_ram_we,
    output wire [7:0]  o_ram_wdata,
    // read data and registers
    output wire [7:0]  o_rdata,
    output wire [7:0]  o_arithmetic_flags,
    output wire [7:0]  o_data_bank_selector
);
    reg  [4:0]  flags_reg;
    reg  [4:0]  flags_next;
    reg  [3:0]  bank_reg;
    reg  [3:0]  bank_next;
    wire [7:0]  alu_result;
    wire [4:0]  alu_flags;
    wire [4:0]  alu_touch;
    wire [7:0]  src_data;
    wire [7:0]  status_view;
    wire [7:0]  bank_view;
    wire [11:0] direct_addr;

    function [11:0] form_addr;
        input [7:0] offs;
        input       acc;
        input [3:0] bank;
        begin
            if (!acc)
                // low half bank 0, high half the special registers
                form_addr = (offs < `ACCESS_SPLIT) ? {`LOW_BANK, offs}
                    : {`SFR_BANK, offs};
            else
                form_addr = {bank, offs};
        end
    endfunction

    function implemented;
        input [11:0] a;
        begin
            // the special register page is always present
            implemented = ({1'b0, a[11:8]} < `IMPL_BANKS)
                || (a[11:8] == `SFR_BANK);
        end
    endfunction

    assign direct_addr = form_addr(i_file_addr, i_access_sel, bank_reg);
    assign o_rd_addr = i_ff_move ? i_ff_src : direct_addr;
    assign o_wr_addr = i_ff_move ? i_ff_dst : direct_addr;
    assign status_view = {3'b000, flags_reg};
    assign bank_view = {4'h0, bank_reg};
    assign src_data = (o_rd_addr == i_status_addr) ? status_view
        : (o_rd_addr == i_bank_addr) ? bank_view
        : implemented(o_rd_addr) ? i_ram_rdata : 8'h00;
    assign o_rdata = src_data;
    // writes to missing banks are dropped; flags still update
    assign o_ram_we = i_exec && (i_write_file || i_ff_move)
        && implemented(o_wr_addr)
        && (o_wr_addr != i_status_addr)
        && (o_wr_addr != i_bank_addr);
    assign o_ram_wdata = i_ff_move ? src_data : alu_result;
    assign o_arithmetic_flags = status_view;
    assign o_data_bank_selector = bank_view;

    flag_alu u_alu
    (
        .i_a        (src_data),
        .i_b        (i_alu_b),
        .i_op       (i_ff_move ? `OP_PLAIN : i_op),
        .i_carry_in (flags_reg[`FLAG_C]),
        .o_result   (alu_result),
        .o_flags    (alu_flags),
        .o_touch    (alu_touch)
    );

    always @*
    begin
        flags_next = flags_reg;
        bank_next = bank_reg;
        if (i_exec)
        begin
            // any flag-changing op blocks the whole five-bit write,
            // so untouched flags keep their value instead of the result
            if ((i_write_file || i_ff_move) && o_wr_addr == i_status_addr
                && alu_touch == 5'h00)
                flags_next = i_ff_move ? src_data[4:0]
                    : alu_result[4:0];
            flags_next = (flags_next & ~alu_touch)
                | (alu_flags & alu_touch);
            if (i_bank_load)
                bank_next = i_literal[3:0];
            else if ((i_write_file || i_ff_move)
                && o_wr_addr == i_bank_addr)
                bank_next = (i_ff_move ? src_data[3:0]
                    : alu_result[3:0]);
        end
    end

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            flags_reg <= `FLAGS_RESET;
            bank_reg <= `BANK_RESET;
        end
        else
        begin
            flags_reg <= flags_next;
            bank_reg <= bank_next;
        end
    end
endmodule
`default_nettype wire

// File: pkg/data_bank_regs.vh
`ifndef DATA_BANK_REGS_VH
`define DATA_BANK_REGS_VH
// window split: low half from bank 0, high half from bank 15
`define ACCESS_SPLIT      8'h80
`define SFR_BANK          4'hf
`define LOW_BANK          4'h0
// number of banks actually backed by ram (arbitrary default)
`define IMPL_BANKS        5'h02
// status field positions
`define FLAG_N            4
`define FLAG_OV           3
`define FLAG_Z            2
`define FLAG_DC           1
`define FLAG_C            0
`define FLAGS_MASK        8'h1f
`define BANK_MASK         8'h0f
`define FLAGS_RESET       5'h00
`define BANK_RESET        4'h0
// alu operation codes
`define OP_NONE           4'h0
`define OP_ADD            4'h1
`define OP_SUB            4'h2
`define OP_LOGIC          4'h3
`define OP_RRC            4'h4
`define OP_RLC            4'h5
`define OP_CLEAR          4'h6
`define OP_PLAIN          4'h7
`endif

// File: rtl/flag_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "data_bank_regs.vh"
module flag_alu
(
    // operands
    input  wire [7:0] i_a,
    input  wire [7:0] i_b,
    input  wire [3:0] i_op,
    input  wire       i_carry_in,
    // result and flags
    output reg  [7:0] o_result,
    output reg  [4:0] o_flags,
    output reg  [4:0] o_touch
);
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] bsel;
    always @*
    begin
        bsel = (i_op == `OP_SUB) ? ~i_b : i_b;
        // subtract adds the complement plus one: carries become not-borrow
        sum = {1'b0, i_a} + {1'b0, bsel} + {8'h00, (i_op == `OP_SUB)};
        nib = {1'b0, i_a[3:0]} + {1'b0, bsel[3:0]}
            + {4'h0, (i_op == `OP_SUB)};
        o_result = i_a;
        o_flags = 5'h00;
        o_touch = 5'h00;
        case (i_op)
            `OP_ADD, `OP_SUB:
            begin
                o_result = sum[7:0];
                o_touch = 5'h1f;
                o_flags[`FLAG_C] = sum[8];
                o_flags[`FLAG_DC] = nib[4];
                o_flags[`FLAG_OV] = (i_a[7] == bsel[7])
                    && (sum[7] != i_a[7]);
            end
            `OP_LOGIC:
            begin
                o_result = i_b;
                o_touch = 5'h14;
            end
            `OP_RRC:
            begin
                // carry and digit-carry flags both come from bit 3 of the source
                o_result = {i_carry_in, i_a[7:1]};
                o_touch = 5'h17;
                o_flags[`FLAG_C] = i_a[3];
                o_flags[`FLAG_DC] = i_a[3];
            end
            `OP_RLC:
            begin
                o_result = {i_a[6:0], i_carry_in};
                o_touch = 5'h17;
                o_flags[`FLAG_C] = i_a[4];
                o_flags[`FLAG_DC] = i_a[4];
            end
            `OP_CLEAR:
            begin
                o_result = 8'h00;
                o_touch = 5'h04;
            end
            default:
            begin
                // bit ops, swap and moves pass through, no flags
                o_result = i_b;
                o_touch = 5'h00;
            end
        endcase
        o_flags[`FLAG_N] = o_result[7];
        o_flags[`FLAG_Z] = (o_result == 8'h00);
    end
endmodule
`default_nettype wire

// File: sim/ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module ram_model
(
    // ram ports as seen from the block
    input  wire logic        i_clk,
    input  wire logic [11:0] i_rd_addr,
    input  wire logic [11:0] i_wr_addr,
    input  wire logic        i_we,
    input  wire logic [7:0]  i_wdata,
    output wire logic [7:0]  o_rdata
);
    logic [7:0] mem [0:4095];
    // preload low address byte so operands are known without writes
    initial for (int k = 0; k < 4096; k++) mem[k] = k[7:0];
    assign o_rdata = mem[i_rd_addr];
    always @(posedge i_clk) if (i_we) mem[i_wr_addr] <= i_wdata;
endmodule
`default_nettype wire

// File: sim/data_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "data_bank_regs.vh"
module data_bank_props
(
    // clock, reset, decode
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_exec,
    input wire logic [7:0]  i_file_addr,
    input wire logic        i_access_sel,
    input wire logic        i_ff_move,
    input wire logic [11:0] i_ff_src,
    input wire logic [11:0] i_ff_dst,
    input wire logic        i_bank_load,
    input wire logic [7:0]  i_literal,
    input wire logic [3:0]  i_op,
    input wire logic [7:0]  i_alu_b,
    // ram and registers
    input wire logic [11:0] o_rd_addr,
    input wire logic [11:0] o_wr_addr,
    input wire logic        o_ram_we,
    input wire logic [7:0]  o_rdata,
    input wire logic [7:0]  o_arithmetic_flags,
    input wire logic [7:0]  o_data_bank_selector
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire       win = !i_access_sel && !i_ff_move;
    wire [3:0] rb  = o_rd_addr[11:8];
    wire [3:0] wb  = o_wr_addr[11:8];
    sequence load_taken; i_exec && i_bank_load; endsequence
    sequence logic_taken; i_exec && i_op == `OP_LOGIC; endsequence
    chk_window_low: assert property (win && !i_file_addr[7] |->
        o_rd_addr == {4'h0, i_file_addr}) else $error("window low wrong");
    chk_window_high: assert property (win && i_file_addr[7] |->
        o_rd_addr == {4'hf, i_file_addr}) else $error("window high wrong");
    chk_bank_addr: assert property (i_access_sel && !i_ff_move |->
        o_rd_addr == {o_data_bank_selector[3:0], i_file_addr})
        else $error("bank address wrong");
    chk_upper_zero: assert property (o_data_bank_selector[7:4] == 4'h0 &&
        o_arithmetic_flags[7:5] == 3'h0) else $error("upper bits set");
    chk_move_addrs: assert property (i_ff_move |-> o_rd_addr == i_ff_src
        && o_wr_addr == i_ff_dst) else $error("move address wrong");
    chk_bank_load: assert property (load_taken |=>
        o_data_bank_selector == ($past(i_literal) & 8'h0f))
        else $error("bank load wrong");
    chk_missing_bank: assert property ((rb > 4'h1 && rb != 4'hf |->
        o_rdata == 8'h00) and (wb > 4'h1 && wb != 4'hf |-> !o_ram_we))
        else $error("missing bank reached");
    chk_logic_flags: assert property (logic_taken |=>
        o_arithmetic_flags[2] == ($past(i_alu_b) == 8'h00) &&
        o_arithmetic_flags[4] == ($past(i_alu_b) >= 8'h80))
        else $error("logic flags wrong");
endmodule
bind data_bank_and_alu_status data_bank_props chk (.*);
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "data_bank_regs.vh"
module tb_top;
    logic        i_clk = 0, i_nrst = 0, i_exec = 0, i_access_sel = 0;
    logic        i_ff_move = 0, i_bank_load = 0, i_write_file = 0;
    logic [3:0]  i_op = 0;
    logic [7:0]  i_file_addr = 0, i_literal = 0, i_alu_b = 0;
    logic [11:0] i_ff_src = 0, i_ff_dst = 0;
    logic [11:0] i_status_addr = 12'hfd8, i_bank_addr = 12'hfe0;
    wire  [7:0]  i_ram_rdata, o_ram_wdata, o_rdata;
    wire  [7:0]  o_arithmetic_flags, o_data_bank_selector;
    wire  [11:0] o_rd_addr, o_wr_addr;
    wire         o_ram_we;
    int          n_fail = 0, compares = 0;
    always #12.5 i_clk = ~i_clk;
    data_bank_and_alu_status dut (.*);
    ram_model ram (.i_clk(i_clk), .i_rd_addr(o_rd_addr),
        .i_wr_addr(o_wr_addr), .i_we(o_ram_we), .i_wdata(o_ram_wdata),
        .o_rdata(i_ram_rdata));
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    // one instruction, entered just after an edge
    task ex(input logic a, input logic [7:0] f, input logic [3:0] op,
            input logic [7:0] b, input logic w);
    begin
        i_access_sel = a; i_file_addr = f; i_op = op;
        i_alu_b = b; i_write_file = w; i_exec = 1;
        @(posedge i_clk);
        #2 i_exec = 0; i_bank_load = 0; i_ff_move = 0;
    end
    endtask
    task bl(input logic [7:0] v);
    begin
        i_bank_load = 1; i_literal = v; ex(0, 0, `OP_NONE, 0, 0);
    end
    endtask
    task tally_and_finish;
    begin
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (20) @(posedge i_clk);
        #2 i_nrst = 1;
        chk("flags", 8'h00, o_arithmetic_flags);
        ex(0, 8'h7f, `OP_ADD, 8'h01, 0);
        chk("flags", 8'h1a, o_arithmetic_flags);
        ex(0, 8'h80, `OP_SUB, 8'h01, 0);
        chk("flags", 8'h09, o_arithmetic_flags);
        ex(0, 8'h05, `OP_SUB, 8'h05, 0);
        chk("flags", 8'h07, o_arithmetic_flags);
        bl(8'hf3);
        chk("bank", 8'h03, o_data_bank_selector);
        ex(1, 8'h20, `OP_ADD, 8'h81, 1);
        chk("flags", 8'h10, o_arithmetic_flags);
        bl(8'h01);
        ex(1, 8'h30, `OP_ADD, 8'hd0, 1);
        chk("flags", 8'h05, o_arithmetic_flags);
        ex(1, 8'h30, `OP_ADD, 8'h00, 0);
        chk("flags", 8'h04, o_arithmetic_flags);
        ex(0, 8'hd8, `OP_ADD, 8'h01, 1);
        chk("flags", 8'h00, o_arithmetic_flags);
        ex(0, 8'h05, `OP_SUB, 8'h01, 0);
        ex(0, 8'hd8, `OP_CLEAR, 8'h00, 1);
        chk("flags", 8'h07, o_arithmetic_flags);
        ex(0, 8'h00, `OP_LOGIC, 8'h80, 0);
        chk("flags", 8'h13, o_arithmetic_flags);
        i_ff_move = 1; i_ff_src = 12'h142; i_ff_dst = 12'h061;
        ex(0, 8'h00, `OP_PLAIN, 8'h00, 1);
        chk("flags", 8'h13, o_arithmetic_flags);
        ex(0, 8'h61, `OP_ADD, 8'h00, 0);
        chk("flags", 8'h00, o_arithmetic_flags);
        ex(0, 8'h18, `OP_RLC, 8'h00, 0);
        chk("flags", 8'h03, o_arithmetic_flags);
        ex(0, 8'h08, `OP_RRC, 8'h00, 0);
        chk("flags", 8'h13, o_arithmetic_flags);
        tally_and_finish();
    end
endmodule
`default_nettype wire
